// [hw/aofr_clk_edge.sv]
`default_nettype none

// ==========================================================
// converter clock pin: synchroniser and edge pulses
// ==========================================================
module aofr_clk_edge
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_pin,
	output logic o_rise,
	output logic o_fall
);
	typedef struct packed
	{
		logic meta;
		logic sync;
		logic prev;
	} aofr_edge_t;

	aofr_edge_t st_r;
	aofr_edge_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		// the first stage feeds only the second stage
		st_nxt.meta = i_pin;
		st_nxt.sync = st_r.meta;
		st_nxt.prev = st_r.sync;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_rise = st_r.sync & ~st_r.prev;
	assign o_fall = ~st_r.sync & st_r.prev;
endmodule

`default_nettype wire

// [hw/aofr_top.sv]
`default_nettype none

// ==========================================================
// shared constants
// ==========================================================
package aofr_pkg;
	localparam int unsigned AOFR_CODE_W = 12;
	// the core hands over signed counts about mid-scale; spare bits let it show clamping
	localparam int unsigned AOFR_IN_W = 14;
	localparam int unsigned AOFR_LATENCY = 3;
	localparam logic [11:0] AOFR_CODE_ZERO = 12'h000;
	localparam logic [11:0] AOFR_CODE_MID = 12'h800;
	localparam logic [11:0] AOFR_CODE_FULL = 12'hfff;
	localparam logic signed [13:0] AOFR_IN_MIN = -14'sd2048;
	localparam logic signed [13:0] AOFR_IN_MAX = 14'sd2047;
	localparam logic [11:0] AOFR_RST_CODE = 12'h000;

	// returns {out_of_range, straight binary code}
	function automatic logic [12:0] aofr_encode(input logic signed [13:0] x);
		logic [13:0] biased;
		biased = 14'(x - AOFR_IN_MIN);
		if (x < AOFR_IN_MIN)
			aofr_encode = {1'b1, AOFR_CODE_ZERO};
		else if (x > AOFR_IN_MAX)
			aofr_encode = {1'b1, AOFR_CODE_FULL};
		else
			aofr_encode = {1'b0, biased[11:0]};
	endfunction
endpackage

// Summary of operation
// - every result leaves as positive-true straight binary, any input range
// - minus reference gives 000, zero gives 800, top-minus-one gives FFF, flag low
// - input below minus reference gives all zeros with flag high
// - input at or above plus reference gives all ones with flag high
// - flag and word of one sample share the same pipeline delay
// - flag low for in-range samples, high for samples beyond range
// - flag stays high until an in-range conversion completes
// - internal timing uses both rising and falling converter clock edges
module aofr_top
	import aofr_pkg::*;
#(
	parameter int unsigned LATENCY = AOFR_LATENCY
)
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_conv_clk,
	input wire logic signed [AOFR_IN_W-1:0] i_core_code,
	output logic [AOFR_CODE_W-1:0] o_data,
	output logic o_out_of_range_flag,
	output logic o_data_valid
);
	typedef struct packed
	{
		logic [LATENCY-1:0][AOFR_CODE_W-1:0] pipe_code;
		logic [LATENCY-1:0] pipe_flag;
		logic [AOFR_CODE_W-1:0] data;
		logic flag;
		logic valid;
	} aofr_state_t;

	aofr_state_t st_r;
	aofr_state_t st_nxt;
	logic conv_rise;
	logic conv_fall;
	logic [12:0] enc;

	// ==========================================================
	// converter clock edges
	// ==========================================================
	// the pin clock is retimed onto i_mclk; a sample clock derived elsewhere
	// should already be retimed by its source else jitter lands here
	aofr_clk_edge u_edge
	(
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_pin(i_conv_clk),
		.o_rise(conv_rise),
		.o_fall(conv_fall)
	);

	// ==========================================================
	// encode, pipeline and output stage
	// ==========================================================
	// straight binary
	assign enc = aofr_encode(i_core_code);

	always_comb
	begin
		st_nxt = st_r;
		// the valid pulse lasts one cycle; a rise and a fall never share a cycle
		st_nxt.valid = 1'b0;
		if (conv_rise)
		begin
			st_nxt.pipe_code[0] = enc[11:0];
			st_nxt.pipe_flag[0] = enc[12];
			for (int i = 1; i < LATENCY; i++)
			begin
				st_nxt.pipe_code[i] = st_r.pipe_code[i-1];
				st_nxt.pipe_flag[i] = st_r.pipe_flag[i-1];
			end
		end
		if (conv_fall)
		begin
			st_nxt.data = st_r.pipe_code[LATENCY-1];
			st_nxt.flag = st_r.pipe_flag[LATENCY-1];
			st_nxt.valid = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			st_r <= '0;
			st_r.data <= AOFR_RST_CODE;
		end
		else
			st_r <= st_nxt;
	end

	assign o_data = st_r.data;
	assign o_out_of_range_flag = st_r.flag;
	assign o_data_valid = st_r.valid;

	// ==========================================================
	// assertions
	// ==========================================================
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);

	chk_binary_output: assert property (
		conv_fall |=> o_data == $past(st_r.pipe_code[LATENCY-1]))
		else $error("output word is not the pipeline tail code");

	chk_code_points: assert property (
		conv_rise && (i_core_code == AOFR_IN_MIN || i_core_code == 14'sd0
			|| i_core_code == AOFR_IN_MAX)
		|=> !st_r.pipe_flag[0] && (st_r.pipe_code[0] == AOFR_CODE_ZERO
			|| st_r.pipe_code[0] == AOFR_CODE_MID || st_r.pipe_code[0] == AOFR_CODE_FULL))
		else $error("edge code point encoded wrongly");

	chk_underrange_clamp: assert property (
		conv_rise && i_core_code < AOFR_IN_MIN
		|=> st_r.pipe_flag[0] && st_r.pipe_code[0] == AOFR_CODE_ZERO)
		else $error("underrange not clamped to zero with flag");

	chk_overrange_clamp: assert property (
		conv_rise && i_core_code > AOFR_IN_MAX
		|=> st_r.pipe_flag[0] && st_r.pipe_code[0] == AOFR_CODE_FULL)
		else $error("overrange not clamped to full with flag");

	chk_flag_latency: assert property (
		conv_fall |=> o_out_of_range_flag == $past(st_r.pipe_flag[LATENCY-1])
			&& o_data_valid)
		else $error("flag not aligned with its word");

	chk_flag_meaning: assert property (
		o_out_of_range_flag |-> o_data == AOFR_CODE_ZERO || o_data == AOFR_CODE_FULL)
		else $error("flag high on a code that is not a rail");

	chk_flag_hold: assert property (
		!conv_fall |=> $stable(o_out_of_range_flag))
		else $error("flag changed without a completed conversion");

	chk_fall_update: assert property (
		!$past(conv_fall) |-> $stable(o_data) && !o_data_valid)
		else $error("output moved off the falling edge");

	chk_one_word: assert property (
		o_data_valid |=> !o_data_valid)
		else $error("more than one word per converter cycle");

	// independent of the encoder: an offset of half scale only flips the top bit
	chk_binary_map: assert property (
		conv_rise && i_core_code >= AOFR_IN_MIN && i_core_code <= AOFR_IN_MAX
		|=> st_r.pipe_code[0] == ($past(i_core_code[AOFR_CODE_W-1:0]) ^ AOFR_CODE_MID))
		else $error("in-range input not encoded as offset binary");

	chk_low_code: assert property (
		conv_rise && i_core_code == AOFR_IN_MIN
		|=> st_r.pipe_code[0] == AOFR_CODE_ZERO && !st_r.pipe_flag[0])
		else $error("minus reference not encoded as zero code");

	chk_mid_code: assert property (
		conv_rise && i_core_code == 14'sd0
		|=> st_r.pipe_code[0] == AOFR_CODE_MID && !st_r.pipe_flag[0])
		else $error("zero input not encoded as mid code");

	chk_top_code: assert property (
		conv_rise && i_core_code == AOFR_IN_MAX
		|=> st_r.pipe_code[0] == AOFR_CODE_FULL && !st_r.pipe_flag[0])
		else $error("top input not encoded as full code");

	chk_flag_clear: assert property (
		conv_fall && !st_r.pipe_flag[LATENCY-1] |=> !o_out_of_range_flag)
		else $error("flag kept high after an in-range conversion");

	chk_valid_source: assert property (
		o_data_valid |-> $past(conv_fall))
		else $error("word marked new without a converter fall");

	// ==========================================================
	// cover points
	// ==========================================================
	cov_underrange: cover property (conv_rise && i_core_code < AOFR_IN_MIN);
	cov_overrange: cover property (conv_rise && i_core_code > AOFR_IN_MAX);
	cov_word_out: cover property (o_data_valid && !o_out_of_range_flag);
	cov_mid_code: cover property (conv_rise && i_core_code == 14'sd0);
	cov_flag_clear: cover property (o_data_valid && $fell(o_out_of_range_flag));
endmodule

`default_nettype wire

// [verif/aofr_capture.sv]
`default_nettype none
// ========
// receiving logic: latch word, decode
module aofr_capture
	import aofr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_valid,
	input wire logic [AOFR_CODE_W-1:0] i_data,
	input wire logic i_flag,
	output logic [AOFR_CODE_W-1:0] o_twos,
	output logic o_under,
	output logic o_over
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge i_mclk)
	begin
		if (i_valid)
		begin
			o_twos <= {~i_data[11], i_data[10:0]};
			o_under <= i_flag & ~i_data[11];
			o_over <= i_flag & i_data[11];
		end
	end
endmodule
`default_nettype wire

// [verif/test_adc_output_format_range_flag.sv]
`default_nettype none
// ========
// bench
module test_adc_output_format_range_flag;
	import aofr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_conv_clk = 1'b0;
	logic [13:0] i_core_code = 14'h0000;
	logic [11:0] o_data;
	logic [11:0] twos;
	logic o_flag, o_valid, under, over;
	int fails = 0;
	int num_checks = 0;
	logic [12:0] exp_q[$];
	always #2.5 i_mclk = ~i_mclk;
	aofr_top #(.LATENCY(3)) i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_conv_clk(i_conv_clk), .i_core_code(i_core_code), .o_data(o_data),
		.o_out_of_range_flag(o_flag), .o_data_valid(o_valid));
	aofr_capture i_cap (.i_mclk(i_mclk), .i_valid(o_valid), .i_data(o_data),
		.i_flag(o_flag), .o_twos(twos), .o_under(under), .o_over(over));
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
		num_checks++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic s);
		num_checks++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [12:0] model(input logic signed [13:0] x);
		if (x < AOFR_IN_MIN)
			return {1'b1, 12'h000};
		if (x > AOFR_IN_MAX)
			return {1'b1, 12'hfff};
		return {1'b0, 12'(x + 14'sh0800)};
	endfunction
	// one conversion, judging the word that leaves the pipe meanwhile
	task automatic conv(input logic [13:0] c);
		logic [12:0] e;
		int n;
		exp_q.push_back(model(c));
		e = exp_q.pop_front();
		@(negedge i_mclk);
		i_core_code = c;
		i_conv_clk = 1'b1;
		repeat (5) @(negedge i_mclk);
		i_conv_clk = 1'b0;
		for (n = 0; n < 10 && o_valid !== 1'b1; n++)
			@(negedge i_mclk);
		chk_bit("valid", 1'b1, o_valid);
		chk("data", e[11:0], o_data);
		chk_bit("flag", e[12], o_flag);
		@(negedge i_mclk);
		chk_bit("pulse", 1'b0, o_valid);
		chk("twos", e[11:0] ^ 12'h800, twos);
		chk_bit("over", e[12] & e[11], over);
		chk_bit("under", e[12] & ~e[11], under);
	endtask
	task automatic done(input string n);
		conv(14'h0000);
		conv(14'h0000);
		$display("test %s done", n);
	endtask
	task automatic t_scale();
		conv(14'h3800);
		conv(14'h0000);
		conv(14'h07ff);
		done("scale");
	endtask
	task automatic t_under();
		conv(14'h37ff);
		conv(14'h2000);
		done("under");
	endtask
	task automatic t_over();
		conv(14'h0800);
		conv(14'h1fff);
		done("over");
	endtask
	task automatic t_recover();
		conv(14'h1fff);
		conv(14'h0800);
		conv(14'h0001);
		done("recover");
	endtask
	initial
	begin
		repeat (12) @(negedge i_mclk);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_mclk);
		exp_q = '{13'h0000, 13'h0000};
		t_scale();
		t_under();
		t_over();
		t_recover();
		print_verdict();
	end
	initial
	begin
		repeat (5000) @(posedge i_mclk);
		fails++;
		print_verdict();
	end
endmodule
`default_nettype wire
